// [tcc_pkg.sv]
// package: register map, field layout, codes and timing for the capture block
`default_nettype none
package tcc_pkg;
  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ     = 100;        // pclk rate
  localparam int unsigned FILT_NS     = 40;         // least stable time
  // least time rounds up to whole cycles
  localparam int unsigned FILT_CYC    = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0]  FILT_CYC_M1 = 3'(FILT_CYC - 1);

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_CTRL  = 8'h92;  // capture_enable_and_flags
  localparam logic [7:0] IDX_EDGE  = 8'h93;  // capture_edge_select
  localparam logic [7:0] IDX_FILT  = 8'h94;  // capture_filter_enable
  localparam logic [7:0] IDX_ISTAT = 8'ha0;  // interrupt status, write one
  localparam logic [7:0] IDX_IMASK = 8'ha1;  // interrupt mask

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned EN_LSB   = 4;      // enables at 6:4
  localparam int unsigned FLAG_LSB = 0;      // flags at 2:0
  localparam int unsigned AUX_BIT  = 6;      // chan2_aux_bit
  localparam int unsigned FILT_LSB = 4;      // filter enables at 6:4
  localparam int unsigned EDGE_W   = 2;      // edge field width
  localparam logic [7:0]  RST_REG  = 8'h00;  // every register

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_RSVD = 2'h3
  } tcc_edge_t;

  typedef enum logic {
    APB_IDLE = 1'h0,  // waiting for a setup cycle
    APB_ACK  = 1'h1   // access phase answered
  } tcc_apb_t;

  // byte address of a register index
  function automatic logic [11:0] tcc_addr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction : tcc_addr

  // does the level pair match the selected edge
  function automatic logic tcc_edge_hit(input logic [1:0] sel,
                                        input logic       prev,
                                        input logic       cur);
    case (sel)
      EDGE_FALL: return prev & ~cur;
      EDGE_RISE: return ~prev & cur;
      EDGE_BOTH: return prev ^ cur;
      default:   return 1'b0;
    endcase
  endfunction : tcc_edge_hit
endpackage : tcc_pkg
`default_nettype wire

// [tcc_capture.sv]
// module: three-channel input capture control with apb registers
// Operation
// - per-channel enable bits at six, five, four
// - selected edge on enabled channel sets flag
// - flag sticky; only software clears, writing zero
// - edge code: fall, rise, either, reserved
// - edge fields at 5:4, 3:2, 1:0
// - per-channel filter enable at bits six-four
// - all control registers reset to zero
`timescale 1ns/1ps
`default_nettype none
module tcc_capture (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // capture pins and events
  input  wire logic [2:0]  cap_pin,
  output logic      [2:0]  cap_event,
  // interrupt
  output logic             irq
);
  import tcc_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [2:0]  en_q;       // chanN_capture_on
  logic [2:0]  flag_q;     // chanN_event_flag
  logic [2:0]  flag_d;
  logic [5:0]  sel_q;      // chanN_edge_sel, two bits each
  logic        aux_q;      // chan2_aux_bit, storage only
  logic [2:0]  filt_q;     // chanN_filter_on
  logic [2:0]  istat_q;    // sticky interrupt status
  logic [2:0]  istat_d;
  logic [2:0]  imask_q;    // interrupt mask
  tcc_apb_t    state_q;    // apb phase
  tcc_apb_t    state_d;
  logic [31:0] prdata_q;   // read data, loaded in setup
  logic        pready_q;
  logic        pslverr_q;
  logic [2:0]  evt_q;      // registered capture pulse
  logic        irq_q;

  // ****************************************************************
  // pin path: sync, filter, edge
  // ****************************************************************
  logic [2:0] s1_q;        // first sync stage, read by s2_q only
  logic [2:0] s2_q;        // second sync stage
  logic [2:0] lvl_q;       // filtered level
  logic [2:0] prev_q;      // level one cycle ago
  logic [2:0] cnt_q [3];   // filter counters
  logic [2:0] hit;         // selected edge seen
  logic [2:0] evt;         // edge on an enabled channel

  // two flops before any logic looks at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= cap_pin;
      s2_q <= s1_q;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_chan
    // filter: a new level is taken only after it held FILT_CYC cycles,
    // so glitches shorter than that never reach edge detection
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lvl_q[i] <= 1'b0;
        cnt_q[i] <= 3'h0;
      end else if (!filt_q[i]) begin
        lvl_q[i] <= s2_q[i];                 // unfiltered path
        cnt_q[i] <= 3'h0;
      end else if (s2_q[i] == lvl_q[i]) begin
        cnt_q[i] <= 3'h0;                    // glitch over, restart
      end else if (cnt_q[i] == FILT_CYC_M1) begin
        lvl_q[i] <= s2_q[i];                 // held long enough
        cnt_q[i] <= 3'h0;
      end else begin
        cnt_q[i] <= cnt_q[i] + 3'h1;
      end
    end

    // edge decode per selected code
    assign hit[i] = tcc_edge_hit(sel_q[EDGE_W*i +: EDGE_W],
                                 prev_q[i], lvl_q[i]);
    // prev tracks even while disabled, so enabling makes no false edge
    assign evt[i] = en_q[i] & hit[i];
  end

  // previous level for edge compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_q <= 3'h0;
    else          prev_q <= lvl_q;
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable & (state_q == APB_ACK);
  wire wr_lane = access & pwrite & pstrb[0];   // only low byte is mapped
  wire hit_ctl = (paddr == tcc_addr(IDX_CTRL));
  wire hit_edg = (paddr == tcc_addr(IDX_EDGE));
  wire hit_flt = (paddr == tcc_addr(IDX_FILT));
  wire hit_ist = (paddr == tcc_addr(IDX_ISTAT));
  wire hit_imk = (paddr == tcc_addr(IDX_IMASK));
  wire mapped  = hit_ctl | hit_edg | hit_flt | hit_ist | hit_imk;
  wire wr_ctl  = wr_lane & hit_ctl;
  wire wr_edg  = wr_lane & hit_edg;
  wire wr_flt  = wr_lane & hit_flt;
  wire wr_ist  = wr_lane & hit_ist;
  wire wr_imk  = wr_lane & hit_imk;

  // writing zero clears a flag, writing one leaves it alone
  wire [2:0] flag_clr = wr_ctl ? ~pwdata[FLAG_LSB +: 3] : 3'h0;
  wire [2:0] ist_clr  = wr_ist ? pwdata[2:0] : 3'h0;

  // read mux, reserved bits read zero
  wire [7:0] rd_ctl = {1'b0, en_q, 1'b0, flag_q};
  wire [7:0] rd_edg = {1'b0, aux_q, sel_q};
  wire [7:0] rd_flt = {1'b0, filt_q, 4'h0};
  wire [7:0] rd_byte = hit_ctl ? rd_ctl :
                       hit_edg ? rd_edg :
                       hit_flt ? rd_flt :
                       hit_ist ? {5'h0, istat_q} :
                       hit_imk ? {5'h0, imask_q} : 8'h00;

  // ****************************************************************
  // next state
  // ****************************************************************
  // a new event wins over a clear in the same cycle
  assign flag_d  = (flag_q & ~flag_clr) | evt;
  assign istat_d = (istat_q & ~ist_clr) | evt;
  assign state_d = (state_q == APB_IDLE && setup) ? APB_ACK : APB_IDLE;

  // ****************************************************************
  // control registers
  // ****************************************************************
  // all control state comes up zero: disabled, falling, unfiltered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q    <= RST_REG[EN_LSB +: 3];
      flag_q  <= RST_REG[FLAG_LSB +: 3];
      sel_q   <= RST_REG[5:0];
      aux_q   <= RST_REG[AUX_BIT];
      filt_q  <= RST_REG[FILT_LSB +: 3];
      istat_q <= 3'h0;
      imask_q <= 3'h0;
    end else begin
      flag_q  <= flag_d;
      istat_q <= istat_d;
      if (wr_ctl) en_q <= pwdata[EN_LSB +: 3];
      if (wr_edg) begin
        sel_q <= pwdata[5:0];
        aux_q <= pwdata[AUX_BIT];
      end
      if (wr_flt) filt_q  <= pwdata[FILT_LSB +: 3];
      if (wr_imk) imask_q <= pwdata[2:0];
    end
  end

  // ****************************************************************
  // bus answer and outputs, all from flops
  // ****************************************************************
  // no wait state even with a registered prdata: data loads in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= APB_IDLE;
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      pready_q <= (state_d == APB_ACK);
      if (state_d == APB_ACK) begin
        prdata_q  <= pwrite ? 32'h0 : {24'h0, rd_byte};
        pslverr_q <= ~mapped;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // capture pulse in step with the status, level interrupt one cycle behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      evt_q <= evt;
      irq_q <= |(istat_q & imask_q);
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign cap_event = evt_q;
  assign irq       = irq_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    evt[1] |=> flag_q[1] && cap_event[1])
    else $error("event did not set flag and pulse");

  a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    flag_q[0] && !(wr_ctl && !pwdata[0]) |=> flag_q[0])
    else $error("flag cleared without a zero write");

  a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !en_q[2] |=> !cap_event[2] && (flag_q[2] || !$past(flag_q[2]) ||
      $past(wr_ctl)) && !(flag_q[2] && !$past(flag_q[2])))
    else $error("disabled channel raised activity");

  a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl |=> en_q == $past(pwdata[6:4]))
    else $error("enable bits not stored");

  a_rise_dec: assert property (@(posedge pclk) disable iff (!presetn)
    en_q[1] && sel_q[3:2] == EDGE_RISE && !prev_q[1] && lvl_q[1]
      |=> cap_event[1] ##1 (!cap_event[1] || $past(evt[1])))
    else $error("rising edge missed on channel 1");

  a_rsvd_none: assert property (@(posedge pclk) disable iff (!presetn)
    sel_q[1:0] == EDGE_RSVD |-> !evt[0])
    else $error("reserved code produced an event");

  a_edge_map: assert property (@(posedge pclk) disable iff (!presetn)
    wr_edg ##1 !wr_edg |-> rd_edg[3:2] == $past(pwdata[3:2], 1))
    else $error("edge field misplaced");

  a_filt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    filt_q[1] && $past(filt_q[1]) && lvl_q[1] != $past(lvl_q[1])
      |-> $past(cnt_q[1]) == FILT_CYC_M1)
    else $error("filter passed a short pulse");

  a_reset_zero: assert property (@(posedge pclk)
    !presetn |-> rd_ctl == 8'h00 && rd_edg == 8'h00 && rd_flt == 8'h00)
    else $error("registers not zero in reset");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (istat_q & imask_q) != 3'h0 |=> irq)
    else $error("interrupt not raised");

  a_irq_low: assert property (@(posedge pclk) disable iff (!presetn)
    (istat_q & imask_q) == 3'h0 |=> !irq)
    else $error("interrupt raised without cause");

  a_flag_w0clr: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctl && !pwdata[1] && !evt[1] |=> !flag_q[1])
    else $error("zero write did not clear flag");

  a_no_selfclr: assert property (@(posedge pclk) disable iff (!presetn)
    flag_q[2] && !wr_ctl |=> flag_q[2])
    else $error("flag dropped by hardware");

  a_fall_dec: assert property (@(posedge pclk) disable iff (!presetn)
    en_q[0] && sel_q[1:0] == EDGE_FALL && prev_q[0] && !lvl_q[0] |-> evt[0])
    else $error("falling edge missed on channel 0");

  a_both_dec: assert property (@(posedge pclk) disable iff (!presetn)
    en_q[2] && sel_q[5:4] == EDGE_BOTH && prev_q[2] != lvl_q[2] |-> evt[2])
    else $error("either-edge change missed on channel 2");

  a_off_ch0: assert property (@(posedge pclk) disable iff (!presetn)
    !en_q[0] |=> !cap_event[0] && (!flag_q[0] || $past(flag_q[0])))
    else $error("disabled channel 0 raised activity");

  a_filt_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    !filt_q[1] |=> lvl_q[1] == $past(s2_q[1]))
    else $error("unfiltered level did not follow pin");

  a_filt_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_flt |=> filt_q == $past(pwdata[6:4]))
    else $error("filter enables not stored");

  a_edge_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_edg |=> sel_q[5:4] == $past(pwdata[5:4]) && sel_q[1:0] == $past(pwdata[1:0]))
    else $error("edge fields not stored");

  // the spare bit has no function; it only has to read back
  a_aux_keep: assert property (@(posedge pclk) disable iff (!presetn)
    wr_edg |=> aux_q == $past(pwdata[AUX_BIT]))
    else $error("spare edge bit not stored");

  a_ist_set: assert property (@(posedge pclk) disable iff (!presetn)
    evt[2] |=> istat_q[2] && flag_q[2])
    else $error("event did not set status");

  a_ist_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ist && pwdata[0] && !evt[0] |=> !istat_q[0])
    else $error("status not cleared by one");

  a_ist_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    istat_q[1] && !(wr_ist && pwdata[1]) |=> istat_q[1])
    else $error("status dropped without a write");

  // ****************************************************************
  // bus answer checks
  // ****************************************************************
  // pready is registered, so a stuck phase would show here first
  a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  a_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");

  // ****************************************************************
  // cover points
  // ****************************************************************
  // main scenarios: edge codes, the filter, a clear race, the interrupt
  c_rise_ch1: cover property (@(posedge pclk) disable iff (!presetn)
    en_q[1] && sel_q[3:2] == EDGE_RISE ##1 cap_event[1]);
  c_both_ch2: cover property (@(posedge pclk) disable iff (!presetn)
    sel_q[5:4] == EDGE_BOTH && evt[2]);
  c_clr_race: cover property (@(posedge pclk) disable iff (!presetn)
    evt[0] && flag_clr[0]);
  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq));
  c_filt_pass: cover property (@(posedge pclk) disable iff (!presetn)
    filt_q[1] && evt[1]);
endmodule : tcc_capture
`default_nettype wire

// [tcc_pin_model.sv]
// partner model: outside signals that drive the three capture pins
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  // clock
  input  wire logic       pclk,
  // pins toward the block
  output var  logic [2:0] cap_pin
);
  // pins idle low until a scenario moves them
  initial cap_pin = 3'h0;

  // ****************************************************************
  // level changes, always just after a rising edge
  // ****************************************************************
  // holding a level is the caller's job; no pulse narrower than a cycle
  task automatic drive(input int ch, input logic lvl);
    @(posedge pclk);
    cap_pin[ch] <= lvl;
  endtask : drive
endmodule : tcc_pin_model
`default_nettype wire

// [three_channel_capture_control_test.sv]
// testbench: register, edge, filter and interrupt checks for the capture block
`timescale 1ns/1ps
`default_nettype none
module three_channel_capture_control_test;
  import tcc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, strb;
  logic [2:0]  cap_pin, cap_event;
  logic        er;
  int          err_total, tests_run, cyc, ev_n;

  tcc_capture i_tcc_capture (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_pin(cap_pin), .cap_event(cap_event), .irq(irq));
  tcc_pin_model i_tcc_pin_model (.pclk(pclk), .cap_pin(cap_pin));

  always #5 pclk = ~pclk;
  // count cycles carrying any capture pulse; a hang ends as a mismatch
  always @(posedge pclk) begin
    cyc++;
    if (cap_event !== 3'h0) ev_n++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // one apb transfer; waits for pready however long it takes
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    pstrb   <= strb;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string nm);
    apb(1'b0, idx, 8'h00);
    chk(nm, exp, rd);
    chk("read error", 32'h0, {31'h0, er});
  endtask : rdc

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [7:0] ids [5];
    ids = '{IDX_CTRL, IDX_EDGE, IDX_FILT, IDX_ISTAT, IDX_IMASK};
    foreach (ids[i]) rdc(ids[i], 32'h0, "reset value");
    apb(1'b0, 8'h99, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, er});
    strb = 4'h0;  // low byte strobe off: write must be dropped
    apb(1'b1, IDX_EDGE, 8'h3f);
    strb = 4'hf;
    rdc(IDX_EDGE, 32'h0, "strobe off");
    apb(1'b1, IDX_EDGE, 8'h7f);
    rdc(IDX_EDGE, 32'h7f, "edge readback");
  endtask : t_reset

  // every edge code, cycling over the three channel fields; reserved reuses channel zero
  task automatic t_edges();
    int ch, e0;
    logic [7:0] en;
    for (int c = 0; c < 4; c++) begin
      ch = c % 3;
      en = 8'h10 << ch;
      apb(1'b1, IDX_EDGE, 8'(c << (2 * ch)));
      apb(1'b1, IDX_CTRL, en);
      e0 = ev_n;
      i_tcc_pin_model.drive(ch, 1'b1);
      repeat (8) @(posedge pclk);
      rdc(IDX_CTRL, en | (8'(c == 1 || c == 2) << ch), "rise flag");
      apb(1'b1, IDX_CTRL, en);
      i_tcc_pin_model.drive(ch, 1'b0);
      repeat (8) @(posedge pclk);
      rdc(IDX_CTRL, en | (8'(c == 0 || c == 2) << ch), "fall flag");
      chk("event pulses", (c == 2) ? 2 : ((c == 3) ? 0 : 1), ev_n - e0);
      apb(1'b1, IDX_CTRL, 8'h00);
    end
  endtask : t_edges

  // only channel two enabled; the other two pins toggle too
  task automatic t_disabled();
    int e0;
    apb(1'b1, IDX_EDGE, 8'h2a);
    apb(1'b1, IDX_CTRL, 8'h40);
    e0 = ev_n;
    for (int ch = 0; ch < 3; ch++) begin
      i_tcc_pin_model.drive(ch, 1'b1);
      repeat (8) @(posedge pclk);
      i_tcc_pin_model.drive(ch, 1'b0);
      repeat (8) @(posedge pclk);
    end
    rdc(IDX_CTRL, 32'h44, "enabled flag only");
    chk("event pulses", 32'h2, ev_n - e0);
  endtask : t_disabled

  // writing ones keeps flags, only a zero clears
  task automatic t_sticky();
    apb(1'b1, IDX_CTRL, 8'h47);
    rdc(IDX_CTRL, 32'h44, "flag after write one");
    repeat (20) @(posedge pclk);
    rdc(IDX_CTRL, 32'h44, "flag held");
    apb(1'b1, IDX_CTRL, 8'h40);
    rdc(IDX_CTRL, 32'h40, "flag cleared");
  endtask : t_sticky

  // a two-cycle glitch is lost, a steady level passes
  task automatic t_filter();
    apb(1'b1, IDX_FILT, 8'h20);
    rdc(IDX_FILT, 32'h20, "filter readback");
    apb(1'b1, IDX_CTRL, 8'h20);
    i_tcc_pin_model.drive(1, 1'b1);
    @(posedge pclk);
    i_tcc_pin_model.drive(1, 1'b0);
    repeat (14) @(posedge pclk);
    rdc(IDX_CTRL, 32'h20, "glitch dropped");
    i_tcc_pin_model.drive(1, 1'b1);
    repeat (14) @(posedge pclk);
    rdc(IDX_CTRL, 32'h22, "steady edge kept");
    i_tcc_pin_model.drive(1, 1'b0);
    apb(1'b1, IDX_FILT, 8'h00);
    repeat (8) @(posedge pclk);  // let the late falling edge land first
  endtask : t_filter

  task automatic t_irq();
    apb(1'b1, IDX_ISTAT, 8'h07);
    rdc(IDX_ISTAT, 32'h0, "status cleared");
    apb(1'b1, IDX_CTRL, 8'h10);
    i_tcc_pin_model.drive(0, 1'b1);
    repeat (8) @(posedge pclk);
    rdc(IDX_ISTAT, 32'h1, "status set");
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, IDX_IMASK, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, IDX_ISTAT, 8'h01);
    repeat (2) @(posedge pclk);
    chk("irq dropped", 32'h0, {31'h0, irq});
    rdc(IDX_IMASK, 32'h1, "mask readback");
  endtask : t_irq

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    strb  = 4'hf;
    pstrb = 4'hf;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_edges();
    t_disabled();
    t_sticky();
    t_filter();
    t_irq();
    results();
  end
endmodule : three_channel_capture_control_test
`default_nettype wire
